// ==== rtl/charge_cycle_sequencer.sv ====
// Charge cycle state machine driving switch gate enable and two open-drain indicators.
// Assumes comparator levels from analog circuitry; analog loops use cur_target and cv_mode.
`timescale 1ns/1ns
`include "charge_cycle_sequencer_defs.svh"
module charge_cycle_sequencer (
  input  wire logic                               core_clk_in,
  input  wire logic                               srst_in,
  input  wire charge_cycle_sequencer_pkg::comp_t  comp_in,
  output logic                                    switch_gate_drive_out,
  output logic [`CCS_CUR_W-1:0]                   current_target_out,
  output logic                                    cv_mode_out,
  output logic                                    charging_indicator_n_out,
  output logic                                    charging_indicator_n_oe_out,
  output logic                                    done_indicator_n_out,
  output logic                                    done_indicator_n_oe_out,
  output charge_cycle_sequencer_pkg::chg_state_t  state_out
);
  charge_cycle_sequencer_pkg::seq_state_t s_q;
  charge_cycle_sequencer_pkg::seq_state_t s_d;
  charge_cycle_sequencer_pkg::comp_t      c;
  logic                                   temp_ok;
  logic                                   awake;
  logic                                   can_start;
  logic                                   fault;

  function automatic charge_cycle_sequencer_pkg::chg_state_t start_state(
    input logic above_pre);
    start_state = above_pre ? charge_cycle_sequencer_pkg::ST_CC
                            : charge_cycle_sequencer_pkg::ST_TRICKLE; // [R02]
  endfunction

  function automatic logic is_charging(input charge_cycle_sequencer_pkg::chg_state_t st);
    is_charging = (st == charge_cycle_sequencer_pkg::ST_TRICKLE) ||
                  (st == charge_cycle_sequencer_pkg::ST_CC) ||
                  (st == charge_cycle_sequencer_pkg::ST_CV);
  endfunction

  always_comb begin
    c         = s_q.sync2;
    temp_ok   = c.temp_below_hot && !c.temp_above_cold; // [R11]
    awake     = c.supply_ok && c.supply_above_bat; // [R09] [R10]
    can_start = awake; // [R01]
    fault     = !awake || !temp_ok || c.bat_overvoltage; // [R18]
    s_d       = s_q;
    s_d.sync1 = comp_in; // [R18]
    s_d.sync2 = s_q.sync1;
    if (!awake) begin
      s_d.state = c.supply_ok ? charge_cycle_sequencer_pkg::ST_SLEEP
                              : charge_cycle_sequencer_pkg::ST_OFF; // [R09] [R10]
    end else begin
      unique case (s_q.state)
        charge_cycle_sequencer_pkg::ST_OFF,
        charge_cycle_sequencer_pkg::ST_SLEEP: begin
          if (can_start) begin
            s_d.state = start_state(c.bat_above_precharge); // [R01] [R08]
          end
        end
        charge_cycle_sequencer_pkg::ST_TRICKLE,
        charge_cycle_sequencer_pkg::ST_CC,
        charge_cycle_sequencer_pkg::ST_CV: begin
          if (!temp_ok) begin
            s_d.resume = s_q.state;
            s_d.state  = charge_cycle_sequencer_pkg::ST_SUSPEND; // [R12]
          end else if (s_q.state == charge_cycle_sequencer_pkg::ST_TRICKLE) begin
            if (c.bat_above_precharge) begin
              s_d.state = charge_cycle_sequencer_pkg::ST_CC; // [R04]
            end
          end else if (s_q.state == charge_cycle_sequencer_pkg::ST_CC) begin
            if (c.bat_at_regulation) begin
              s_d.state = charge_cycle_sequencer_pkg::ST_CV; // [R05]
            end
          end else if (c.current_at_eoc) begin
            s_d.state = charge_cycle_sequencer_pkg::ST_DONE; // [R06]
          end
        end
        charge_cycle_sequencer_pkg::ST_DONE: begin
          if (c.bat_below_recharge) begin
            s_d.state = start_state(c.bat_above_precharge); // [R07] [R16]
          end
        end
        charge_cycle_sequencer_pkg::ST_SUSPEND: begin
          if (temp_ok) begin
            s_d.state = s_q.resume; // [R12]
          end
        end
        default: s_d.state = charge_cycle_sequencer_pkg::ST_OFF;
      endcase
    end
    s_d.drive_on   = is_charging(s_d.state) && !fault; // [R06] [R13] [R18]
    s_d.cur_target = (s_d.state == charge_cycle_sequencer_pkg::ST_TRICKLE)
                     ? `CCS_CUR_TRICKLE : `CCS_CUR_FULL; // [R03] [R04]
    s_d.cv_mode    = (s_d.state == charge_cycle_sequencer_pkg::ST_CV); // [R05]
    s_d.chg_ind    = is_charging(s_d.state) && awake && temp_ok; // [R14] [R17]
    s_d.done_ind   = (s_d.state == charge_cycle_sequencer_pkg::ST_DONE) && awake
                     && temp_ok; // [R15] [R17]
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign switch_gate_drive_out       = s_q.drive_on;
  assign current_target_out          = s_q.cur_target;
  assign cv_mode_out                 = s_q.cv_mode;
  assign charging_indicator_n_out    = 1'b0;
  assign charging_indicator_n_oe_out = s_q.chg_ind; // [R14]
  assign done_indicator_n_out        = 1'b0;
  assign done_indicator_n_oe_out     = s_q.done_ind; // [R15]
  assign state_out                   = s_q.state;

  property p_sleep;
    @(posedge core_clk_in) disable iff (srst_in)
      !s_q.sync2.supply_above_bat |=> !switch_gate_drive_out && !charging_indicator_n_oe_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("charging while asleep"); // [R09]

  property p_lockout;
    @(posedge core_clk_in) disable iff (srst_in)
      !s_q.sync2.supply_ok |=> state_out == charge_cycle_sequencer_pkg::ST_OFF;
  endproperty
  a_lockout: assert property (p_lockout) else $error("not off in lockout"); // [R10]

  property p_ov;
    @(posedge core_clk_in) disable iff (srst_in)
      s_q.sync2.bat_overvoltage |=> !switch_gate_drive_out;
  endproperty
  a_ov: assert property (p_ov) else $error("switch on in overvoltage"); // [R13]

  property p_trickle_cur;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_TRICKLE
      |-> current_target_out == `CCS_CUR_TRICKLE;
  endproperty
  a_trickle_cur: assert property (p_trickle_cur) else $error("wrong trickle target"); // [R03]

  property p_done_ind;
    @(posedge core_clk_in) disable iff (srst_in)
      done_indicator_n_oe_out |-> state_out == charge_cycle_sequencer_pkg::ST_DONE
                                  && !charging_indicator_n_oe_out;
  endproperty
  a_done_ind: assert property (p_done_ind) else $error("done indicator mismatch"); // [R15]

  property p_eoc;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_CV && s_q.sync2.current_at_eoc
      && s_q.sync2.supply_ok && s_q.sync2.supply_above_bat && temp_ok
      |=> state_out == charge_cycle_sequencer_pkg::ST_DONE ##0 !switch_gate_drive_out;
  endproperty
  a_eoc: assert property (p_eoc) else $error("no termination at end current"); // [R06]

  property p_temp;
    @(posedge core_clk_in) disable iff (srst_in)
      !temp_ok |=> !switch_gate_drive_out && !charging_indicator_n_oe_out
                   && !done_indicator_n_oe_out;
  endproperty
  a_temp: assert property (p_temp) else $error("active out of temperature window"); // [R17]

  property p_recharge;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_DONE && s_q.sync2.bat_below_recharge
      && awake && temp_ok |=> charging_indicator_n_oe_out;
  endproperty
  a_recharge: assert property (p_recharge) else $error("no recharge restart"); // [R07]

  property p_idle_hold;
    @(posedge core_clk_in) disable iff (srst_in)
      (state_out == charge_cycle_sequencer_pkg::ST_OFF
       || state_out == charge_cycle_sequencer_pkg::ST_SLEEP) && !awake
      |=> !is_charging(state_out) && !switch_gate_drive_out;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("started without supply"); // [R01]

  property p_start_trickle;
    @(posedge core_clk_in) disable iff (srst_in)
      (state_out == charge_cycle_sequencer_pkg::ST_OFF
       || state_out == charge_cycle_sequencer_pkg::ST_SLEEP) && awake
      && !s_q.sync2.bat_above_precharge
      |=> state_out == charge_cycle_sequencer_pkg::ST_TRICKLE;
  endproperty
  a_start_trickle: assert property (p_start_trickle) else $error("no trickle start"); // [R02]

  property p_start_cc;
    @(posedge core_clk_in) disable iff (srst_in)
      (state_out == charge_cycle_sequencer_pkg::ST_OFF
       || state_out == charge_cycle_sequencer_pkg::ST_SLEEP) && awake
      && s_q.sync2.bat_above_precharge
      |=> state_out == charge_cycle_sequencer_pkg::ST_CC;
  endproperty
  a_start_cc: assert property (p_start_cc) else $error("no full current start"); // [R04]

  property p_trickle_to_cc;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_TRICKLE && awake && temp_ok
      && s_q.sync2.bat_above_precharge
      |=> state_out == charge_cycle_sequencer_pkg::ST_CC
          && current_target_out == `CCS_CUR_FULL;
  endproperty
  a_trickle_to_cc: assert property (p_trickle_to_cc) else $error("trickle not left"); // [R04]

  property p_cc_to_cv;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_CC && awake && temp_ok
      && s_q.sync2.bat_at_regulation
      |=> state_out == charge_cycle_sequencer_pkg::ST_CV && cv_mode_out;
  endproperty
  a_cc_to_cv: assert property (p_cc_to_cv) else $error("no voltage mode"); // [R05]

  property p_cv_flag;
    @(posedge core_clk_in) disable iff (srst_in)
      cv_mode_out == (state_out == charge_cycle_sequencer_pkg::ST_CV);
  endproperty
  a_cv_flag: assert property (p_cv_flag) else $error("voltage mode flag wrong"); // [R05]

  property p_full_target;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_CC
      || state_out == charge_cycle_sequencer_pkg::ST_CV
      |-> current_target_out == `CCS_CUR_FULL;
  endproperty
  a_full_target: assert property (p_full_target) else $error("wrong full target"); // [R04]

  property p_drive_states;
    @(posedge core_clk_in) disable iff (srst_in)
      switch_gate_drive_out |-> is_charging(state_out);
  endproperty
  a_drive_states: assert property (p_drive_states) else $error("switch on when idle"); // [R18]

  property p_done_entry;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_DONE
      |-> $past(state_out) == charge_cycle_sequencer_pkg::ST_DONE
          || $past(state_out) == charge_cycle_sequencer_pkg::ST_CV;
  endproperty
  a_done_entry: assert property (p_done_entry) else $error("bad entry to done"); // [R06]

  property p_recharge_ind;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_DONE && s_q.sync2.bat_below_recharge
      && awake && temp_ok
      |=> is_charging(state_out) && !done_indicator_n_oe_out;
  endproperty
  a_recharge_ind: assert property (p_recharge_ind) else $error("no toggle"); // [R16]

  property p_done_hold;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_DONE && !s_q.sync2.bat_below_recharge
      && awake |=> state_out == charge_cycle_sequencer_pkg::ST_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("left done early"); // [R07]

  property p_done_show;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_DONE && !s_q.sync2.bat_below_recharge
      && awake && temp_ok |=> done_indicator_n_oe_out && !done_indicator_n_out;
  endproperty
  a_done_show: assert property (p_done_show) else $error("done not shown"); // [R15]

  property p_ov_clear;
    @(posedge core_clk_in) disable iff (srst_in)
      is_charging(state_out) && awake && temp_ok && !s_q.sync2.bat_overvoltage
      |=> switch_gate_drive_out || state_out == charge_cycle_sequencer_pkg::ST_DONE;
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("switch stays off"); // [R13]

  property p_enter_suspend;
    @(posedge core_clk_in) disable iff (srst_in)
      is_charging(state_out) && awake && !temp_ok
      |=> state_out == charge_cycle_sequencer_pkg::ST_SUSPEND
          && s_q.resume == $past(state_out);
  endproperty
  a_enter_suspend: assert property (p_enter_suspend) else $error("no suspend"); // [R12]

  property p_resume;
    @(posedge core_clk_in) disable iff (srst_in)
      state_out == charge_cycle_sequencer_pkg::ST_SUSPEND && awake && temp_ok
      |=> state_out == $past(s_q.resume);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // [R12]

  property p_sync;
    @(posedge core_clk_in) disable iff (srst_in)
      !$past(srst_in) |-> s_q.sync1 == $past(comp_in) && s_q.sync2 == $past(s_q.sync1);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser skipped"); // [R18]

  property p_lockout_ind;
    @(posedge core_clk_in) disable iff (srst_in)
      !s_q.sync2.supply_ok |=> !switch_gate_drive_out && !charging_indicator_n_oe_out
                               && !done_indicator_n_oe_out;
  endproperty
  a_lockout_ind: assert property (p_lockout_ind) else $error("active in lockout"); // [R17]

  property p_sleep_state;
    @(posedge core_clk_in) disable iff (srst_in)
      s_q.sync2.supply_ok && !s_q.sync2.supply_above_bat
      |=> state_out == charge_cycle_sequencer_pkg::ST_SLEEP && !done_indicator_n_oe_out;
  endproperty
  a_sleep_state: assert property (p_sleep_state) else $error("not asleep"); // [R09]

  c_full_cycle: cover property (@(posedge core_clk_in) disable iff (srst_in)
    state_out == charge_cycle_sequencer_pkg::ST_CV ##1
    state_out == charge_cycle_sequencer_pkg::ST_DONE);
  c_trickle_cc: cover property (@(posedge core_clk_in) disable iff (srst_in)
    state_out == charge_cycle_sequencer_pkg::ST_TRICKLE ##1
    state_out == charge_cycle_sequencer_pkg::ST_CC);
  c_suspend: cover property (@(posedge core_clk_in) disable iff (srst_in)
    state_out == charge_cycle_sequencer_pkg::ST_SUSPEND);
  c_recharge: cover property (@(posedge core_clk_in) disable iff (srst_in)
    state_out == charge_cycle_sequencer_pkg::ST_DONE ##1
    state_out == charge_cycle_sequencer_pkg::ST_CC);
  c_overvolt: cover property (@(posedge core_clk_in) disable iff (srst_in)
    state_out == charge_cycle_sequencer_pkg::ST_CV && !switch_gate_drive_out);
endmodule

// ==== rtl/charge_cycle_sequencer_defs.svh ====
// Constants for the charge cycle sequencer: current width and targets, sense reference and trickle percentage.
// Assumes comparator outputs arrive as clean logic levels from the analog front end.
// Function
// R01: Start a cycle only above undervoltage lockout and supply above battery by margin.
// R02: At cycle start with battery below 11.2V, enter trickle charge.
// R03: Trickle current target is about 15% of full-scale current.
// R04: Above 11.2V charge at full-scale constant current, 200mV sense reference.
// R05: At 16.8V regulation voltage move to constant-voltage operation.
// R06: At end-of-charge current terminate, hold switch drive off at the supply.
// R07: From terminated, restart when battery falls below 16V with input present.
// R08: Removing then restoring input supply restarts a charge cycle.
// R09: Input absent or below battery voltage puts the sequencer in sleep; with supply_ok low the code goes to ST_OFF instead.
// R10: Below undervoltage lockout level of about 6V the charger stays off.
// R11: Thermistor below 175mV is too hot, above 1.61V too cold.
// R12: Out-of-window temperature suspends charging; it resumes once back in range.
// R13: Battery overshoot above 8% turns the switch off until cleared.
// R14: Charging indicator pulled low while charging, high impedance otherwise.
// R15: Done indicator pulled low while terminated, high impedance otherwise.
// R16: Without battery, cycling makes both indicators toggle as a pulse train.
// R17: Both indicators released in lockout, sleep or temperature fault.
// R18: Comparators synchronised; faults override charging states on switch drive.
`ifndef CHARGE_CYCLE_SEQUENCER_DEFS_SVH
`define CHARGE_CYCLE_SEQUENCER_DEFS_SVH
`define CCS_CUR_W        8
`define CCS_CUR_FULL     8'hC8
`define CCS_CUR_TRICKLE  8'h1E
`define CCS_SENSE_REF_MV 8'hC8
`define CCS_TRICKLE_PCT  8'h0F
`endif

// ==== rtl/charge_cycle_sequencer_pkg.sv ====
// Types for the charge cycle sequencer.
// Assumes the defs header is compiled alongside.
package charge_cycle_sequencer_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_TRICKLE, ST_CC, ST_CV, ST_DONE, ST_SLEEP, ST_SUSPEND
  } chg_state_t;

  typedef struct packed {
    logic supply_ok;
    logic supply_above_bat;
    logic bat_above_precharge;
    logic bat_at_regulation;
    logic bat_below_recharge;
    logic current_at_eoc;
    logic temp_below_hot;
    logic temp_above_cold;
    logic bat_overvoltage;
  } comp_t;

  typedef struct packed {
    comp_t      sync1;
    comp_t      sync2;
    chg_state_t state;
    chg_state_t resume;
    logic       drive_on;
    logic [7:0] cur_target;
    logic       cv_mode;
    logic       chg_ind;
    logic       done_ind;
  } seq_state_t;
endpackage

// ==== verif/charge_env_model.sv ====
// Far-side model: supply, battery, thermistor and indicator pull-ups.
// Assumes the bench sets analog levels in tenths of a volt and millivolts.
`timescale 1ns/1ns
module charge_env_model #(
  parameter int MARGIN_DV = 4,
  parameter int EOC_PCT = 10
) (
  input  wire logic [7:0]                        vcc_dv_in,
  input  wire logic [7:0]                        bat_dv_in,
  input  wire logic [11:0]                       temp_mv_in,
  input  wire logic [7:0]                        cur_pct_in,
  input  wire logic                              chg_out_in,
  input  wire logic                              chg_oe_in,
  input  wire logic                              done_out_in,
  input  wire logic                              done_oe_in,
  output charge_cycle_sequencer_pkg::comp_t      comp_out,
  output logic                                   chg_pin_out,
  output logic                                   done_pin_out
);
  always_comb begin
    comp_out.supply_ok           = vcc_dv_in > 8'h3C;
    comp_out.supply_above_bat    = {1'b0, vcc_dv_in}
                                   > ({1'b0, bat_dv_in} + 9'(MARGIN_DV));
    comp_out.bat_above_precharge = bat_dv_in > 8'h70;
    comp_out.bat_at_regulation   = bat_dv_in >= 8'hA8;
    comp_out.bat_below_recharge  = bat_dv_in < 8'hA0;
    comp_out.current_at_eoc      = cur_pct_in <= 8'(EOC_PCT);
    comp_out.temp_below_hot      = temp_mv_in > 12'h0AF;
    comp_out.temp_above_cold     = temp_mv_in > 12'h64A;
    comp_out.bat_overvoltage     = bat_dv_in > 8'hB5;
  end
  // Pull-ups on the open-drain indicators
  assign chg_pin_out  = chg_oe_in ? chg_out_in : 1'b1;
  assign done_pin_out = done_oe_in ? done_out_in : 1'b1;
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the charge cycle sequencer.
// Assumes the environment model stands in for supply, battery and thermistor.
`timescale 1ns/1ns
module tb_top;
  localparam logic [14:0] ALL = 15'h7FFF;
  localparam logic [14:0] NOT = 15'h7803;
  logic core_clk_in, srst_in, gate_on, cv, chg_o, chg_oe, dn_o, dn_oe, chg_pin, dn_pin;
  logic [7:0] tgt, vcc, battery_sense, cur;
  logic [11:0] temp;
  int mismatches, n_compared;
  charge_cycle_sequencer_pkg::comp_t comp;
  charge_cycle_sequencer_pkg::chg_state_t st;
  charge_env_model i_env (.vcc_dv_in(vcc), .bat_dv_in(battery_sense), .temp_mv_in(temp),
    .cur_pct_in(cur), .chg_out_in(chg_o), .chg_oe_in(chg_oe), .done_out_in(dn_o),
    .done_oe_in(dn_oe), .comp_out(comp), .chg_pin_out(chg_pin), .done_pin_out(dn_pin));
  charge_cycle_sequencer i_dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .comp_in(comp),
    .switch_gate_drive_out(gate_on), .current_target_out(tgt), .cv_mode_out(cv),
    .charging_indicator_n_out(chg_o), .charging_indicator_n_oe_out(chg_oe),
    .done_indicator_n_out(dn_o), .done_indicator_n_oe_out(dn_oe), .state_out(st));
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic env(input int v, input int b, input int t, input int c);
    @(posedge core_clk_in);
    vcc  <= 8'(v);
    battery_sense  <= 8'(b);
    temp <= 12'(t);
    cur  <= 8'(c);
    repeat (4) @(posedge core_clk_in);
    #1;
  endtask
  task automatic ex(input charge_cycle_sequencer_pkg::chg_state_t s, input logic [11:0] o,
                    input logic [14:0] m);
    logic [14:0] got;
    logic [14:0] exp;
    got = {st, gate_on, tgt, cv, chg_pin, dn_pin};
    exp = {s, o};
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  task automatic t_cycle();
    env(200, 100, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_TRICKLE, {1'b1, 8'h1E, 3'b001}, ALL);
    env(200, 130, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_CC, {1'b1, 8'hC8, 3'b001}, ALL);
    for (int i = 0; i < 2; i++) begin
      env(200, 168, 500, 100);
      ex(charge_cycle_sequencer_pkg::ST_CV, {1'b1, 8'h00, 3'b101}, 15'h7807);
      env(200, 168, 500, 5);
      ex(charge_cycle_sequencer_pkg::ST_DONE, {1'b0, 8'h00, 3'b010}, NOT);
      env(200, 159, 500, 100);
      ex(charge_cycle_sequencer_pkg::ST_CC, {1'b1, 8'hC8, 3'b001}, ALL);
    end
  endtask
  task automatic t_overvolt();
    env(200, 168, 500, 100);
    env(200, 185, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_CV, {1'b0, 8'h00, 3'b101}, 15'h7807);
    env(200, 168, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_CV, {1'b1, 8'h00, 3'b101}, 15'h7807);
  endtask
  task automatic t_temp();
    env(200, 168, 100, 100);
    ex(charge_cycle_sequencer_pkg::ST_SUSPEND, {1'b0, 8'h00, 3'b011}, NOT);
    env(200, 168, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_CV, {1'b1, 8'h00, 3'b101}, 15'h7807);
    env(200, 168, 1700, 100);
    ex(charge_cycle_sequencer_pkg::ST_SUSPEND, {1'b0, 8'h00, 3'b011}, NOT);
    env(200, 168, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_CV, {1'b1, 8'hC8, 3'b101}, ALL);
  endtask
  task automatic t_sleep();
    env(168, 168, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_SLEEP, {1'b0, 8'h00, 3'b011}, NOT);
    env(50, 150, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_OFF, {1'b0, 8'h00, 3'b011}, NOT);
    env(200, 150, 500, 100);
    ex(charge_cycle_sequencer_pkg::ST_CC, {1'b1, 8'hC8, 3'b001}, ALL);
  endtask
  task automatic final_report();
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    mismatches = 0;
    n_compared = 0;
    srst_in = 1'b1;
    vcc = 8'h00;
    battery_sense = 8'h00;
    temp = 12'h000;
    cur = 8'h00;
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'b0;
    t_cycle();
    t_overvolt();
    t_temp();
    t_sleep();
    final_report();
  end
endmodule
